// File: inc/enc_feedback_pkg.sv
/*
 * constants and types shared by the encoder feedback front end.
 * assumes a single 50 MHz drive clock.
 */
package enc_feedback_pkg;
	localparam int CLK_HZ = 50000000;
	localparam int BASE_SMALL_HZ = 9000000;
	localparam int BASE_LARGE_HZ = 15000000;
	localparam logic [7:0] FILTER_RESET = 8'h00;
	localparam logic [16:0] RES_MIN = 17'h000C8;
	localparam logic [16:0] RES_MAX = 17'h1F400;
	localparam logic [16:0] RES_RESET = 17'h01F40;
	localparam logic [31:0] POS_MAX = 32'h7FFFFFFF;
	localparam logic [31:0] POS_MIN = 32'h80000001;
	localparam logic [31:0] POS_RESET = 32'h00000000;
	localparam logic [7:0] REG_ENC_POS = 8'h35;
	localparam logic SEL_DIFF = 1'b0;
	localparam logic SEL_SINGLE = 1'b1;
	// filter time step: one tick per base period, scaled by the constant
	localparam int TICK_SMALL = CLK_HZ / BASE_SMALL_HZ;
	localparam int TICK_LARGE = CLK_HZ / BASE_LARGE_HZ;
	typedef enum logic [2:0] {
		POS_IDLE = 3'b001,
		POS_LOAD = 3'b010,
		POS_REPLY = 3'b100
	} pos_state_type;
endpackage

// File: logic/enc_input_filter.sv
/*
 * one-channel low-pass noise filter: the input must stay at a new level
 * for the programmed number of base ticks before the output follows.
 * assumes the input is already synchronised to the clock.
 */
`timescale 1ns/1ns
`default_nettype none
module enc_input_filter (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic tick_i,
	input wire logic [7:0] k_i,
	input wire logic d_i,
	output logic q_o
);
	logic [7:0] cnt;
	wire differs = d_i != q_o;
	wire done = cnt >= k_i;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt <= 8'h00;
			q_o <= 1'b0;
		end else if (!differs) begin
			cnt <= 8'h00;
		end else if (done) begin // RULE2
			q_o <= d_i;
			cnt <= 8'h00;
		end else if (tick_i) begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

// File: logic/enc_feedback_config.sv
/*
 * encoder feedback front end: settings, input filter, position counter.
 * assumes a command parser drives the one-cycle command strobes.
 */
// Functional notes
// (RULE1) filter constant is eight-bit value 0 to 255
// (RULE2) cutoff equals base constant over filter constant
// (RULE3) position-set with value loads signed counter
// (RULE4) position-set without value returns count, register 053
// (RULE5) host follows preset with internal position-set
// (RULE6) no position-set while moving under multitasking
// (RULE7) resolution held as counts, 200 to 128000
// (RULE8) flag: 0 differential, 1 single-ended inputs
// (RULE9) quadrature edges count up or down by one
`timescale 1ns/1ns
`default_nettype none
module enc_feedback_config
	import enc_feedback_pkg::*;
#(
	parameter bit SMALL_MODEL = 1'b0
) (
	input wire logic MCLK_I,
	input wire logic NRST_I,
	input wire logic ENC_A_I,
	input wire logic ENC_B_I,
	input wire logic FILTER_WR_I,
	input wire logic [7:0] FILTER_DATA_I,
	input wire logic POS_WR_I,
	input wire logic POS_RD_I,
	input wire logic [31:0] POS_DATA_I,
	input wire logic RES_WR_I,
	input wire logic [16:0] RES_DATA_I,
	input wire logic SEL_WR_I,
	input wire logic SEL_DATA_I,
	input wire logic REG_RD_I,
	input wire logic [7:0] REG_ADDR_I,
	output logic [7:0] FILTER_O,
	output logic [16:0] RES_O,
	output logic RES_ERR_O,
	output logic POS_ERR_O,
	output logic SINGLE_ENDED_O,
	output logic [31:0] POS_O,
	output logic POS_VALID_O,
	output logic [31:0] REG_DATA_O,
	output logic REG_VALID_O
);
	import enc_feedback_pkg::*;

	// ==========================================================
	// helpers
	function automatic logic in_pos_range(input logic [31:0] v);
		return v != 32'h80000000;
	endfunction

	// ==========================================================
	// pin synchronisers
	logic [1:0] a_sync;
	logic [1:0] b_sync;
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			a_sync <= 2'b00;
			b_sync <= 2'b00;
		end else begin
			a_sync <= {a_sync[0], ENC_A_I};
			b_sync <= {b_sync[0], ENC_B_I};
		end
	end

	// ==========================================================
	// settings
	logic [7:0] filter_k;
	logic [16:0] resolution;
	logic single_ended;
	wire res_ok = RES_DATA_I >= RES_MIN && RES_DATA_I <= RES_MAX;
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			filter_k <= FILTER_RESET;
			resolution <= RES_RESET;
			single_ended <= SEL_DIFF;
			RES_ERR_O <= 1'b0;
		end else begin
			if (FILTER_WR_I)
				filter_k <= FILTER_DATA_I; // RULE1
			if (RES_WR_I && res_ok)
				resolution <= RES_DATA_I; // RULE7
			if (RES_WR_I)
				RES_ERR_O <= !res_ok; // RULE7
			if (SEL_WR_I)
				single_ended <= SEL_DATA_I; // RULE8
		end
	end
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			FILTER_O <= FILTER_RESET;
			RES_O <= RES_RESET;
			SINGLE_ENDED_O <= SEL_DIFF;
		end else begin
			FILTER_O <= filter_k; // RULE1
			RES_O <= resolution;
			SINGLE_ENDED_O <= single_ended; // RULE8
		end
	end

	// ==========================================================
	// filter base tick; integer division trades exact cutoff for a cheap divider
	localparam int TICK_DIV = SMALL_MODEL ? TICK_SMALL : TICK_LARGE;
	logic [3:0] tick_cnt;
	wire tick = tick_cnt == 4'(TICK_DIV - 1);
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I)
			tick_cnt <= 4'h0;
		else
			tick_cnt <= tick ? 4'h0 : tick_cnt + 4'h1; // RULE2
	end

	logic a_filt;
	logic b_filt;
	enc_input_filter u_filt_a (
		.clk_i(MCLK_I),
		.nrst_i(NRST_I),
		.tick_i(tick),
		.k_i(filter_k),
		.d_i(a_sync[1]),
		.q_o(a_filt)
	);
	enc_input_filter u_filt_b (
		.clk_i(MCLK_I),
		.nrst_i(NRST_I),
		.tick_i(tick),
		.k_i(filter_k),
		.d_i(b_sync[1]),
		.q_o(b_filt)
	);

	// ==========================================================
	// quadrature decode
	logic a_prev;
	logic b_prev;
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			a_prev <= 1'b0;
			b_prev <= 1'b0;
		end else begin
			a_prev <= a_filt;
			b_prev <= b_filt;
		end
	end
	wire a_edge = a_filt != a_prev;
	wire b_edge = b_filt != b_prev;
	// both channels moving at once is an illegal step and is dropped
	wire step = a_edge ^ b_edge;
	wire up = a_edge ? (a_filt != b_filt) : (a_filt == b_filt);

	// ==========================================================
	// position counter and host access
	pos_state_type state;
	pos_state_type next_state;
	logic [31:0] position;
	logic [31:0] pos_latch;
	always_comb begin
		case (state)
			POS_IDLE: begin
				if (POS_WR_I)
					next_state = POS_LOAD;
				else if (POS_RD_I)
					next_state = POS_REPLY;
				else
					next_state = POS_IDLE;
			end
			POS_LOAD: next_state = POS_IDLE;
			POS_REPLY: next_state = POS_IDLE;
			default: next_state = POS_IDLE;
		endcase
	end
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			state <= POS_IDLE;
			pos_latch <= POS_RESET;
		end else begin
			state <= next_state;
			if (state == POS_IDLE && POS_WR_I)
				pos_latch <= POS_DATA_I;
		end
	end
	// the preset wins over a count edge in the same cycle
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			position <= POS_RESET;
			POS_ERR_O <= 1'b0;
		end else if (state == POS_LOAD) begin
			POS_ERR_O <= !in_pos_range(pos_latch);
			if (in_pos_range(pos_latch))
				position <= pos_latch; // RULE3
		end else if (step) begin
			position <= up ? position + 32'h1 : position - 32'h1; // RULE9
		end
	end
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			POS_O <= POS_RESET;
			POS_VALID_O <= 1'b0;
			REG_DATA_O <= 32'h0;
			REG_VALID_O <= 1'b0;
		end else begin
			POS_VALID_O <= state == POS_REPLY; // RULE4
			if (state == POS_REPLY)
				POS_O <= position; // RULE4
			REG_VALID_O <= REG_RD_I;
			if (REG_RD_I)
				REG_DATA_O <= REG_ADDR_I == REG_ENC_POS ? position : 32'h0; // RULE4
		end
	end

	// ==========================================================
	// checks
	sequence s_read_req;
		state == POS_IDLE && !POS_WR_I && POS_RD_I;
	endsequence
	property p_reply;
		@(posedge MCLK_I) disable iff (!NRST_I)
		s_read_req |=> ##1 POS_VALID_O;
	endproperty
	a_reply: assert property (p_reply) else $error("position reply missing"); // RULE4
	property p_load;
		@(posedge MCLK_I) disable iff (!NRST_I)
		(state == POS_IDLE && POS_WR_I && POS_DATA_I != 32'h80000000) |=> ##1
		position == $past(POS_DATA_I, 2);
	endproperty
	a_load: assert property (p_load) else $error("position preset lost"); // RULE3
	property p_res;
		@(posedge MCLK_I) disable iff (!NRST_I)
		resolution >= RES_MIN && resolution <= RES_MAX;
	endproperty
	a_res: assert property (p_res) else $error("resolution out of range"); // RULE7
	property p_count;
		@(posedge MCLK_I) disable iff (!NRST_I)
		(state != POS_LOAD && step && up) |=> position == $past(position) + 32'h1;
	endproperty
	a_count: assert property (p_count) else $error("count up missed"); // RULE9
	property p_sel;
		@(posedge MCLK_I) disable iff (!NRST_I)
		SEL_WR_I |=> ##1 SINGLE_ENDED_O == $past(SEL_DATA_I, 2);
	endproperty
	a_sel: assert property (p_sel) else $error("select flag wrong"); // RULE8
	property p_filter;
		@(posedge MCLK_I) disable iff (!NRST_I)
		FILTER_WR_I |=> ##1 FILTER_O == $past(FILTER_DATA_I, 2);
	endproperty
	a_filter: assert property (p_filter) else $error("filter constant wrong"); // RULE1
	property p_filt_hold;
		@(posedge MCLK_I) disable iff (!NRST_I)
		// the output may follow one clock after the count is reached, tick or not
		(filter_k != 8'h00 && !tick && a_filt != a_sync[1] && u_filt_a.cnt < filter_k)
		|=> a_filt == $past(a_filt);
	endproperty
	a_filt_hold: assert property (p_filt_hold) else $error("filter passed early"); // RULE2
endmodule
`default_nettype wire

// File: bench/enc_quad_model.sv
/*
 quadrature encoder on the far side of the feedback inputs.
 assumes the bench moves the phase no faster than the filter settles.
*/
`timescale 1ns/1ns
`default_nettype none
// ==========
// encoder model
module enc_quad_model (
	input wire logic [1:0] phase_i,
	output logic a_o,
	output logic b_o
);
	// gray code, so only one channel moves per step; a leads b going up
	assign a_o = phase_i[1] ^ phase_i[0];
	assign b_o = phase_i[1];
endmodule
`default_nettype wire

// File: bench/testbench.sv
/*
 self-checking bench for the encoder feedback front end.
 assumes a 50 MHz clock and one-cycle command strobes.
*/
`timescale 1ns/1ns
`default_nettype none
// ==========
// bench top
module testbench;
	import enc_feedback_pkg::*;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [1:0] phase = 2'h0;
	logic enc_a, enc_b, res_err, pos_err, single_q, pos_vld, reg_vld;
	logic filt_wr = 1'b0, pos_wr = 1'b0, pos_rd = 1'b0, res_wr = 1'b0;
	logic sel_wr = 1'b0, sel_d = 1'b0, reg_rd = 1'b0;
	logic [7:0] filt_d = 8'h00, reg_addr = 8'h00, filt_q;
	logic [31:0] pos_d = 32'h00000000, pos_q, reg_q;
	logic [16:0] res_d = 17'h00000, res_q;
	int err_total = 0;
	int total_checks = 0;
	always #10 mclk = ~mclk;
	enc_quad_model u_enc_quad_model (.phase_i(phase), .a_o(enc_a), .b_o(enc_b));
	enc_feedback_config #(.SMALL_MODEL(1'b0)) u_enc_feedback_config (
		.MCLK_I(mclk), .NRST_I(nrst), .ENC_A_I(enc_a), .ENC_B_I(enc_b),
		.FILTER_WR_I(filt_wr), .FILTER_DATA_I(filt_d), .POS_WR_I(pos_wr),
		.POS_RD_I(pos_rd), .POS_DATA_I(pos_d), .RES_WR_I(res_wr),
		.RES_DATA_I(res_d), .SEL_WR_I(sel_wr), .SEL_DATA_I(sel_d),
		.REG_RD_I(reg_rd), .REG_ADDR_I(reg_addr), .FILTER_O(filt_q),
		.RES_O(res_q), .RES_ERR_O(res_err), .POS_ERR_O(pos_err),
		.SINGLE_ENDED_O(single_q), .POS_O(pos_q), .POS_VALID_O(pos_vld),
		.REG_DATA_O(reg_q), .REG_VALID_O(reg_vld));
	// ==========
	// tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// drop every strobe but reg_rd, then wait until the two-edge answer has landed
	task automatic settle();
		@(negedge mclk);
		{filt_wr, pos_wr, pos_rd, res_wr, sel_wr} = 5'h00;
		repeat (2) @(negedge mclk);
	endtask
	task automatic wr_filt(input logic [7:0] d);
		filt_d = d;
		filt_wr = 1'b1;
		settle();
	endtask
	task automatic wr_res(input logic [16:0] d);
		res_d = d;
		res_wr = 1'b1;
		settle();
	endtask
	task automatic wr_sel(input logic d);
		sel_d = d;
		sel_wr = 1'b1;
		settle();
	endtask
	task automatic wr_pos(input logic [31:0] d);
		pos_d = d;
		pos_wr = 1'b1;
		settle();
	endtask
	task automatic rd_pos(input logic [31:0] exp);
		pos_rd = 1'b1;
		@(negedge mclk);
		pos_rd = 1'b0;
		// the valid pulse stands for one cycle only
		@(negedge mclk);
		chk(pos_vld, 32'h1);
		chk(pos_q, exp);
		@(negedge mclk);
		chk(pos_vld, 32'h0);
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		chk(reg_vld, 32'h1);
		chk(reg_q, exp);
		@(negedge mclk);
	endtask
	task automatic step(input logic up, input int wait_clk);
		phase = up ? phase + 2'h1 : phase - 2'h1;
		repeat (wait_clk) @(negedge mclk);
	endtask
	// ==========
	// tests
	initial begin
		repeat (20) @(negedge mclk);
		nrst = 1'b1;
		chk(filt_q, FILTER_RESET);
		chk(res_q, RES_RESET);
		chk(single_q, SEL_DIFF);
		wr_filt(8'hFF);
		chk(filt_q, 8'hFF);
		wr_filt(8'h00);
		chk(filt_q, 8'h00);
		wr_res(RES_MIN);
		chk(res_q, RES_MIN);
		wr_res(RES_MAX);
		chk(res_q, RES_MAX);
		chk(res_err, 32'h0);
		wr_res(17'h000C7);
		chk(res_q, RES_MAX);
		chk(res_err, 32'h1);
		wr_res(17'h1F401);
		chk(res_err, 32'h1);
		wr_sel(SEL_SINGLE);
		chk(single_q, SEL_SINGLE);
		wr_sel(SEL_DIFF);
		chk(single_q, SEL_DIFF);
		// presets only while the encoder is still, as a host must
		wr_pos(POS_MAX);
		rd_pos(POS_MAX);
		rd_reg(REG_ENC_POS, POS_MAX);
		rd_reg(8'h34, 32'h00000000);
		wr_pos(POS_MIN);
		rd_pos(POS_MIN);
		wr_pos(32'h80000000);
		chk(pos_err, 32'h1);
		rd_pos(POS_MIN);
		wr_pos(32'h00000000);
		chk(pos_err, 32'h0);
		for (int i = 0; i < 4; i++) begin
			step(1'b1, 60);
		end
		rd_pos(32'h00000004);
		step(1'b0, 60);
		step(1'b0, 60);
		rd_pos(32'h00000002);
		// ten ticks of three clocks: the edge must not pass early
		wr_filt(8'h0A);
		step(1'b1, 12);
		rd_pos(32'h00000002);
		repeat (60) @(negedge mclk);
		rd_pos(32'h00000003);
		final_report();
	end
	// the sequence needs under a thousand clocks
	initial begin
		repeat (3000) @(posedge mclk);
		err_total++;
		final_report();
	end
endmodule
`default_nettype wire
